// ===== core/fpg_cmd_if.sv
`timescale 1ns/1ps
interface fpg_cmd_if;
  logic cs_active;
  logic bit_strobe;
  logic bit_value;
  logic opcode_valid;
  logic [7:0] opcode;
  logic cmd_end;
  logic byte_aligned;
  modport framer (
    input cs_active, bit_strobe, bit_value,
    output opcode_valid, opcode, cmd_end, byte_aligned
  );
  modport gate (
    output cs_active, bit_strobe, bit_value,
    input opcode_valid, opcode, cmd_end, byte_aligned
  );
endinterface

// ===== core/fpg_framer.sv
`timescale 1ns/1ps
module fpg_framer
  import fpg_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  fpg_cmd_if.framer cmd
);
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic first_q, first_d;
  logic active_q;
  logic opv_d, end_d, algn_d;
  logic [7:0] opc_d;

  always_comb begin
    cnt_d = cnt_q;
    shift_d = shift_q;
    first_d = first_q;
    opv_d = 1'b0;
    opc_d = cmd.opcode;
    end_d = 1'b0;
    algn_d = cmd.byte_aligned;
    if (cmd.cs_active && cmd.bit_strobe) begin
      shift_d = {shift_q[6:0], cmd.bit_value};
      cnt_d = cnt_q + 3'h1;
      if (cnt_q == 3'(BYTE_BITS - 1) && first_q) begin
        opv_d = 1'b1;
        opc_d = {shift_q[6:0], cmd.bit_value};
        first_d = 1'b0;
      end
    end
    if (active_q && !cmd.cs_active) begin
      // The modulo-eight counter is zero exactly when the frame ended on a byte boundary.
      end_d = 1'b1;
      algn_d = (cnt_q == 3'h0);
      cnt_d = 3'h0;
      first_d = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cnt_q <= 3'h0;
      shift_q <= 8'h00;
      first_q <= 1'b1;
      active_q <= 1'b0;
      cmd.opcode_valid <= 1'b0;
      cmd.opcode <= 8'h00;
      cmd.cmd_end <= 1'b0;
      cmd.byte_aligned <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      first_q <= first_d;
      active_q <= cmd.cs_active;
      cmd.opcode_valid <= opv_d;
      cmd.opcode <= opc_d;
      cmd.cmd_end <= end_d;
      cmd.byte_aligned <= algn_d;
    end
  end
endmodule

// ===== core/fpg_gate.sv
`timescale 1ns/1ps
// Notes on behaviour
// - No command is accepted until initialization ends and standby is entered.
// - Modifying commands are checked for a clock count that is a multiple of eight.
// - In standby, unaligned modifying commands of eight or more clocks are dropped without executing and flagged by an o_discard pulse.
// - In deep sleep only the release opcode is honoured.
// - All instructions are ignored until the power-up delay elapses after supply good.
// - At the end of the power-up delay enter standby and clear the write enable latch.
// - Reset pin or soft restart command restarts initialization.
// - Commands are ignored while supply is below the cut-off level.
// - A dip that stays above cut-off keeps the initialized state.
module fpg_gate
  import fpg_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES = POWER_UP_DELAY_CYCLES
)(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_supply_good,
  input wire logic i_below_cutoff,
  input wire logic i_restart_pin,
  input wire logic i_cs_active,
  input wire logic i_sclk,
  input wire logic i_sdi,
  input wire logic i_cmd_modifies,
  output logic o_ready,
  output logic o_deep_sleep,
  output logic o_write_enable_latch,
  output logic o_opcode_valid,
  output logic [7:0] o_opcode,
  output logic o_execute,
  output logic o_discard
);
  localparam int unsigned CW = $clog2(DELAY_CYCLES + 1);

  // Every pin input except i_cmd_modifies crosses two flops before anything looks at it.
  logic [5:0] sync1_q, sync2_q;
  logic [5:0] sync1_d, sync2_d;
  logic sclk_prev_q;
  logic sclk_prev_d;
  logic good_s, cut_s, rstp_s, cs_s, sclk_s, sdi_s;

  fpg_state_type state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic wel_d, ds_d, rdy_d, opv_d, exe_d, dis_d;
  logic [7:0] opc_d;
  logic mod_q, mod_d;
  logic live_q, live_d;

  fpg_cmd_if cmd ();

  assign good_s = sync2_q[0];
  assign cut_s = sync2_q[1];
  assign rstp_s = sync2_q[2];
  assign cs_s = sync2_q[3];
  assign sclk_s = sync2_q[4];
  assign sdi_s = sync2_q[5];
  assign cmd.cs_active = cs_s;
  assign cmd.bit_strobe = sclk_s && !sclk_prev_q;
  assign cmd.bit_value = sdi_s;

  fpg_framer u_framer (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .cmd(cmd)
  );

  // The synchroniser only shifts pins along; nothing but stage two reads stage one.
  always_comb begin
    sync1_d = {i_sdi, i_sclk, i_cs_active, i_restart_pin, i_below_cutoff, i_supply_good};
    sync2_d = sync1_q;
    sclk_prev_d = sclk_s;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      sclk_prev_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sclk_prev_q <= sclk_prev_d;
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    wel_d = o_write_enable_latch;
    ds_d = 1'b0;
    rdy_d = 1'b0;
    opv_d = 1'b0;
    opc_d = o_opcode;
    exe_d = 1'b0;
    dis_d = 1'b0;
    mod_d = mod_q;
    live_d = live_q;
    unique case (state_q)
      FPG_OFF: begin
        cnt_d = '0;
        wel_d = 1'b0;
        if (good_s && !cut_s) begin
          state_d = FPG_DELAY;
        end
      end
      FPG_DELAY: begin
        if (cnt_q >= CW'(DELAY_CYCLES - 1)) begin
          state_d = FPG_STANDBY;
          wel_d = 1'b0;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      FPG_STANDBY: begin
        rdy_d = 1'b1;
        if (cmd.opcode_valid) begin
          opv_d = 1'b1;
          opc_d = cmd.opcode;
          live_d = 1'b1;
          mod_d = 1'b0;
        end
        if (live_q && i_cmd_modifies) begin
          mod_d = 1'b1;
        end
        if (cmd.cmd_end && live_q) begin
          live_d = 1'b0;
          if ((mod_q || i_cmd_modifies) && !cmd.byte_aligned) begin
            dis_d = 1'b1;
          end else begin
            exe_d = 1'b1;
            if (o_opcode == OPC_WRITE_ENABLE) begin
              wel_d = 1'b1;
            end else if (o_opcode == OPC_WRITE_DISABLE) begin
              wel_d = 1'b0;
            end else if (o_opcode == OPC_DEEP_SLEEP) begin
              state_d = FPG_DEEP_SLEEP;
            end else if (o_opcode == OPC_SOFT_RESTART) begin
              state_d = FPG_DELAY;
              cnt_d = '0;
              wel_d = 1'b0;
            end
          end
        end
      end
      FPG_DEEP_SLEEP: begin
        // Release gives no execute pulse, so a sleeping part can never look busy.
        ds_d = 1'b1;
        live_d = 1'b0;
        if (cmd.cmd_end && cmd.byte_aligned && o_opcode == OPC_RELEASE_FROM_DEEP_SLEEP) begin
          state_d = FPG_STANDBY;
          ds_d = 1'b0;
        end
        if (cmd.opcode_valid) begin
          opc_d = cmd.opcode;
        end
      end
      default: begin
        state_d = FPG_OFF;
      end
    endcase
    // Cut-off forces a fresh initialization; a shallower dip leaves standby and deep sleep untouched but sends off or delay back to off.
    if (cut_s || !good_s) begin
      if (cut_s) begin
        state_d = FPG_OFF;
        live_d = 1'b0;
        rdy_d = 1'b0;
        opv_d = 1'b0;
        exe_d = 1'b0;
        dis_d = 1'b0;
        ds_d = 1'b0;
      end else if (state_q == FPG_OFF || state_q == FPG_DELAY) begin
        state_d = FPG_OFF;
      end
    end
    if (rstp_s && !cut_s) begin
      state_d = good_s ? FPG_DELAY : FPG_OFF;
      cnt_d = '0;
      wel_d = 1'b0;
      live_d = 1'b0;
      rdy_d = 1'b0;
      opv_d = 1'b0;
      exe_d = 1'b0;
      dis_d = 1'b0;
      ds_d = 1'b0;
    end
    // Nothing outside standby may launch a command, whatever the decode above did.
    if (state_q != FPG_STANDBY) begin
      exe_d = 1'b0;
      opv_d = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= FPG_OFF;
      cnt_q <= '0;
      mod_q <= 1'b0;
      live_q <= 1'b0;
      o_ready <= 1'b0;
      o_deep_sleep <= 1'b0;
      o_write_enable_latch <= 1'b0;
      o_opcode_valid <= 1'b0;
      o_opcode <= 8'h00;
      o_execute <= 1'b0;
      o_discard <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      mod_q <= mod_d;
      live_q <= live_d;
      o_ready <= rdy_d;
      o_deep_sleep <= ds_d;
      o_write_enable_latch <= wel_d;
      o_opcode_valid <= opv_d;
      o_opcode <= opc_d;
      o_execute <= exe_d;
      o_discard <= dis_d;
    end
  end
endmodule

// ===== core/fpg_pkg.sv
package fpg_pkg;
  localparam int unsigned CLOCK_HZ = 20_000_000;
  localparam int unsigned POWER_UP_DELAY_US = 300;
  localparam int unsigned POWER_UP_DELAY_CYCLES = (POWER_UP_DELAY_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [7:0] OPC_RELEASE_FROM_DEEP_SLEEP = 8'hab;
  localparam logic [7:0] OPC_DEEP_SLEEP = 8'hb9;
  localparam logic [7:0] OPC_SOFT_RESTART = 8'hf0;
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  typedef enum logic [2:0] {
    FPG_OFF,
    FPG_DELAY,
    FPG_STANDBY,
    FPG_DEEP_SLEEP
  } fpg_state_type;
endpackage

// ===== testbench/flash_command_protection_gate_tb.sv
`timescale 1ns/1ps
module flash_command_protection_gate_tb;
  import fpg_pkg::*;
  localparam int unsigned DELAY_CYCLES = 20;
  logic clock = 1'b0, rst = 1'b1, sup = 1'b0, cut = 1'b0, rpin = 1'b0;
  logic cs, sclk, sdi, mods, ready, sleep, write_enable_latch, opv, exe, dis;
  logic [7:0] opc;
  int error_cnt = 0, checked = 0, cycles = 0, n_exe = 0, n_dis = 0, n, e;
  int n_opv = 0, v;
  always #25 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    n_exe <= n_exe + (exe === 1'b1);
    n_dis <= n_dis + (dis === 1'b1);
    n_opv <= n_opv + (opv === 1'b1);
    if (cycles == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  fpg_host fpg_host_inst (.i_clock(clock), .o_cs_active(cs), .o_sclk(sclk), .o_sdi(sdi),
    .o_modifies(mods));
  fpg_gate #(.DELAY_CYCLES(DELAY_CYCLES)) fpg_gate_inst (.i_clock(clock), .i_rst(rst),
    .i_supply_good(sup), .i_below_cutoff(cut), .i_restart_pin(rpin), .i_cs_active(cs),
    .i_sclk(sclk), .i_sdi(sdi), .i_cmd_modifies(mods), .o_ready(ready), .o_deep_sleep(sleep),
    .o_write_enable_latch(write_enable_latch), .o_opcode_valid(opv), .o_opcode(opc), .o_execute(exe),
    .o_discard(dis));
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task report_and_stop();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wait_ready();
    n = 0;
    while (ready !== 1'b1 && n < 400) begin
      @(posedge clock);
      #1 n++;
    end
    chk("ready wait", 8'h1, {7'h0, ready});
  endtask
  task frame(input logic [15:0] b, input int len, input logic m);
    e = n_exe;
    v = n_opv;
    fpg_host_inst.send(b, len, m);
    repeat (6) @(posedge clock);
    #1;
  endtask
  task t_power();
    repeat (10) @(posedge clock);
    #1 chk("ready off", 8'h0, {7'h0, ready});
    @(posedge clock) sup <= 1'b1;
    wait_ready();
    chk("delay", 8'h1, {7'h0, n >= DELAY_CYCLES});
    chk("wel init", 8'h0, {7'h0, write_enable_latch});
  endtask
  task t_wen();
    frame(16'h0600, 8, 1'b1);
    chk("opcode", OPC_WRITE_ENABLE, opc);
    chk("opcode valid", 8'(v + 1), 8'(n_opv));
    chk("exec", 8'(e + 1), 8'(n_exe));
    chk("wel set", 8'h1, {7'h0, write_enable_latch});
  endtask
  task t_unaligned();
    n = n_dis;
    frame(16'h0400, 11, 1'b1);
    chk("discard", 8'(n + 1), 8'(n_dis));
    chk("no exec", 8'(e), 8'(n_exe));
    chk("wel kept", 8'h1, {7'h0, write_enable_latch});
  endtask
  task t_sleep();
    frame(16'h0400, 8, 1'b1);
    frame(16'hb900, 8, 1'b1);
    chk("sleep", 8'h1, {7'h0, sleep});
    frame(16'h0600, 8, 1'b1);
    chk("sleep exec", 8'(e), 8'(n_exe));
    chk("sleep opv", 8'(v), 8'(n_opv));
    chk("sleep wel", 8'h0, {7'h0, write_enable_latch});
    frame(16'hab00, 8, 1'b0);
    wait_ready();
    chk("woke", 8'h0, {7'h0, sleep});
  endtask
  task t_cutoff();
    frame(16'h0600, 8, 1'b1);
    chk("pre cut wel", 8'h1, {7'h0, write_enable_latch});
    @(posedge clock) cut <= 1'b1;
    repeat (10) @(posedge clock);
    frame(16'h0600, 8, 1'b1);
    chk("cut exec", 8'(e), 8'(n_exe));
    chk("cut opv", 8'(v), 8'(n_opv));
    chk("cut wel", 8'h0, {7'h0, write_enable_latch});
    @(posedge clock) cut <= 1'b0;
    wait_ready();
  endtask
  task t_dip();
    @(posedge clock) sup <= 1'b0;
    repeat (10) @(posedge clock);
    #1 chk("dip ready", 8'h1, {7'h0, ready});
    @(posedge clock) sup <= 1'b1;
    frame(16'h0600, 8, 1'b1);
    chk("dip wel", 8'h1, {7'h0, write_enable_latch});
  endtask
  task t_restart();
    @(posedge clock) rpin <= 1'b1;
    repeat (8) @(posedge clock);
    #1 chk("pin ready", 8'h0, {7'h0, ready});
    @(posedge clock) rpin <= 1'b0;
    wait_ready();
    chk("pin wel", 8'h0, {7'h0, write_enable_latch});
    frame(16'hf000, 8, 1'b1);
    chk("soft ready", 8'h0, {7'h0, ready});
    wait_ready();
    chk("soft back", 8'h1, {7'h0, ready});
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_power();
    t_wen();
    t_unaligned();
    t_sleep();
    t_cutoff();
    t_dip();
    t_restart();
    report_and_stop();
  end
endmodule
bind fpg_gate fpg_gate_chk #(.DELAY_CYCLES(DELAY_CYCLES)) fpg_gate_chk_inst (
  .i_clock(i_clock),
  .i_rst(i_rst),
  .i_below_cutoff(i_below_cutoff),
  .i_restart_pin(i_restart_pin),
  .o_ready(o_ready),
  .o_deep_sleep(o_deep_sleep),
  .o_write_enable_latch(o_write_enable_latch),
  .o_opcode_valid(o_opcode_valid),
  .o_execute(o_execute),
  .o_discard(o_discard)
);

// ===== testbench/fpg_gate_chk.sv
`timescale 1ns/1ps
module fpg_gate_chk
  import fpg_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES = POWER_UP_DELAY_CYCLES
)(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_below_cutoff,
  input wire logic i_restart_pin,
  input wire logic o_ready,
  input wire logic o_deep_sleep,
  input wire logic o_write_enable_latch,
  input wire logic o_opcode_valid,
  input wire logic o_execute,
  input wire logic o_discard
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Counts cycles spent not ready, so a short power-up wait is caught.
  logic [15:0] low_q;
  always_ff @(posedge i_clock) low_q <= (i_rst || o_ready) ? 16'h0 : low_q + 16'h1;
  property p_exe; o_execute |-> $past(o_ready); endproperty
  a_exe: assert property (p_exe) else $error("execute while not ready");
  property p_opv; o_opcode_valid |-> $past(o_ready); endproperty
  a_opv: assert property (p_opv) else $error("opcode while not ready");
  property p_dis; o_discard |-> !o_execute; endproperty
  a_dis: assert property (p_dis) else $error("discard with execute");
  property p_excl; !(o_ready && o_deep_sleep); endproperty
  a_excl: assert property (p_excl) else $error("ready in deep sleep");
  property p_slp; $past(o_deep_sleep) |-> !o_execute; endproperty
  a_slp: assert property (p_slp) else $error("execute in deep sleep");
  property p_cut; i_below_cutoff [*6] |-> !o_execute && !o_opcode_valid; endproperty
  a_cut: assert property (p_cut) else $error("command below cutoff");
  property p_rst; i_restart_pin [*6] |-> !o_ready; endproperty
  a_rst: assert property (p_rst) else $error("ready during restart");
  // Sleep flag drops one cycle before ready rises, hence the look two cycles back.
  property p_dly; $rose(o_ready) && !$past(o_deep_sleep, 2) |-> low_q >= DELAY_CYCLES; endproperty
  a_dly: assert property (p_dly) else $error("power-up wait too short");
  property p_wel; $rose(o_ready) && !$past(o_deep_sleep, 2) |-> !o_write_enable_latch; endproperty
  a_wel: assert property (p_wel) else $error("latch set at standby entry");
endmodule

// ===== testbench/fpg_host.sv
`timescale 1ns/1ps
module fpg_host (
  input wire logic i_clock,
  output logic o_cs_active,
  output logic o_sclk,
  output logic o_sdi,
  output logic o_modifies
);
  initial begin
    o_cs_active = 1'b0;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    o_modifies = 1'b0;
  end
  task automatic send(input logic [15:0] bits, input int n, input logic mod);
    @(posedge i_clock);
    o_cs_active <= 1'b1;
    o_modifies <= mod;
    for (int i = 0; i < n; i++) begin
      o_sdi <= bits[15 - i];
      repeat (2) @(posedge i_clock);
      o_sclk <= 1'b1;
      repeat (2) @(posedge i_clock);
      o_sclk <= 1'b0;
    end
    repeat (2) @(posedge i_clock);
    o_cs_active <= 1'b0;
    // A released data line must not keep its last bit, so it flips.
    o_sdi <= ~o_sdi;
    o_modifies <= 1'b0;
    repeat (4) @(posedge i_clock);
  endtask
endmodule
